// file: pkg/gpc_pkg.sv
// shared constants and types for the pin group 5 low configuration block
package gpc_pkg;

  localparam int NUM_PINS = 4;
  localparam int REG_W = 8;
  localparam int WB_DW = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN5_2 = 8'h41;
  localparam logic [7:0] IDX_PIN5_3 = 8'h42;
  localparam logic [7:0] IDX_PIN5_4 = 8'h43;
  localparam logic [7:0] IDX_PIN5_5 = 8'h44;
  localparam int IDX_LSB = 2;

  // field positions within a pin control register
  localparam int BIT_DIR = 0;
  localparam int BIT_POL = 1;
  localparam int FUNC_LSB = 2;
  localparam int BIT_OD = 7;

  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_ALT = 2'h1;

  // bits that hold state; 6:4 are reserved and read zero
  localparam logic [7:0] CFG_MASK = 8'h8F;

  localparam logic [7:0] RST_PIN5_2 = 8'h01;
  localparam logic [7:0] RST_PIN5_3 = 8'h00;
  localparam logic [7:0] RST_PIN5_4 = 8'h01;
  localparam logic [7:0] RST_PIN5_5 = 8'h01;

  // pins whose serial alternate function is an output (5.3 and 5.5)
  localparam logic [3:0] ALT_IS_OUT = 4'h0A;

  typedef struct packed {
    logic open_drain;
    logic [2:0] reserved;
    logic [1:0] func;
    logic invert;
    logic is_input;
  } gpc_cfg_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [WB_DW-1:0] dat;
  } gpc_wb_req_type;

endpackage

// file: hw/gpc_pin_config.sv
// configuration and pin muxing for general purpose pins 5.2 to 5.5
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps

module gpc_pin_config #(
  parameter int ADR_W = 10
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic main_por,
  input wire logic pci_reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [gpc_pkg::WB_DW-1:0] wb_dat_i,
  output logic [gpc_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pad_i,
  output logic [gpc_pkg::NUM_PINS-1:0] pad_o,
  output logic [gpc_pkg::NUM_PINS-1:0] pad_oe,
  input wire logic [gpc_pkg::NUM_PINS-1:0] gpio_out,
  output logic [gpc_pkg::NUM_PINS-1:0] gpio_in,
  input wire logic serial2_transmit_data,
  input wire logic serial2_request_to_send_n,
  output logic serial2_receive_data,
  output logic serial2_data_set_ready_n
);

  localparam int NP = gpc_pkg::NUM_PINS;
  localparam logic [7:0] IDX [NP] = '{gpc_pkg::IDX_PIN5_2,
    gpc_pkg::IDX_PIN5_3, gpc_pkg::IDX_PIN5_4, gpc_pkg::IDX_PIN5_5};
  localparam logic [7:0] RSTV [NP] = '{gpc_pkg::RST_PIN5_2,
    gpc_pkg::RST_PIN5_3, gpc_pkg::RST_PIN5_4, gpc_pkg::RST_PIN5_5};

  if (ADR_W < gpc_pkg::IDX_LSB + 8) begin : g_bad_adr
    $error("address bus too narrow for the register indices");
  end

  gpc_pkg::gpc_wb_req_type req;
  gpc_pkg::gpc_cfg_type cfg_r [NP];
  logic [7:0] adr_idx;
  logic take;
  logic wr_lo;
  logic [NP-1:0] hit;
  logic [NP-1:0] alt_sel;
  logic [NP-1:0] alt_drive;
  logic [7:0] rd_byte;
  logic wb_ack_r;
  logic [gpc_pkg::WB_DW-1:0] wb_dat_r;
  logic [NP-1:0] pad_o_r;
  logic [NP-1:0] pad_oe_r;
  logic [NP-1:0] gpio_in_r;
  logic rxd_r;
  logic dsr_n_r;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
    sel: wb_sel_i, dat: wb_dat_i};
  assign adr_idx = wb_adr_i[gpc_pkg::IDX_LSB +: 8];
  // one answer per request: ack drops in the cycle after it is given
  assign take = req.cyc && req.stb && !wb_ack_r;
  assign wr_lo = take && req.we && req.sel[0];

  // alternate output sources, one per pin; input pins have none
  assign alt_drive = {serial2_request_to_send_n, 1'b0,
    serial2_transmit_data, 1'b0};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_ack_r <= 1'b0;
    end else begin
      wb_ack_r <= take;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NP; i++) begin
      if (hit[i]) begin
        rd_byte = cfg_r[i] & gpc_pkg::CFG_MASK;
      end
    end
  end

  // unmapped addresses are acknowledged and read zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_dat_r <= '0;
    end else if (take && !req.we) begin
      wb_dat_r <= {{(gpc_pkg::WB_DW-8){1'b0}}, rd_byte};
    end
  end

  // each pin keeps its state in its own flops, so no vector is written
  // by more than one process
  for (genvar i = 0; i < NP; i++) begin : g_pin
    logic pin_rst;
    logic drive_val;
    logic in_val;
    logic drives;
    gpc_pkg::gpc_cfg_type cfg_q;
    logic po_q;
    logic poe_q;
    logic gin_q;

    assign hit[i] = (adr_idx == IDX[i]);
    // 5.3 alone also clears on main power and bus reset
    if (i == 1) begin : g_multi_rst
      assign pin_rst = srst || main_por || pci_reset;
    end else begin : g_vtr_rst
      assign pin_rst = srst;
    end

    always_ff @(posedge core_clk) begin
      if (pin_rst) begin
        cfg_q <= RSTV[i];
      end else if (wr_lo && hit[i]) begin
        cfg_q <= req.dat[7:0] & gpc_pkg::CFG_MASK;
      end
    end
    assign cfg_r[i] = cfg_q;

    assign alt_sel[i] = (cfg_q.func == gpc_pkg::FUNC_ALT);
    // in alternate mode the direction is fixed per pin by ALT_IS_OUT, not by the serial signal
    assign drives = alt_sel[i] ? gpc_pkg::ALT_IS_OUT[i]
                               : !cfg_q.is_input;
    assign drive_val = (alt_sel[i] ? alt_drive[i] : gpio_out[i])
                       ^ cfg_q.invert;
    assign in_val = pad_i[i] ^ cfg_q.invert;

    always_ff @(posedge core_clk) begin
      if (pin_rst) begin
        po_q <= 1'b0;
        poe_q <= 1'b0;
        gin_q <= 1'b0;
      end else begin
        // open drain only ever pulls low, floats for a one
        if (cfg_q.open_drain) begin
          po_q <= 1'b0;
          poe_q <= drives && !drive_val;
        end else begin
          po_q <= drive_val;
          poe_q <= drives;
        end
        gin_q <= in_val;
      end
    end
    assign pad_o_r[i] = po_q;
    assign pad_oe_r[i] = poe_q;
    assign gpio_in_r[i] = gin_q;
  end

  // serial inputs idle high when their pin is in gpio use
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rxd_r <= 1'b1;
      dsr_n_r <= 1'b1;
    end else begin
      rxd_r <= alt_sel[0] ? (pad_i[0] ^ cfg_r[0].invert) : 1'b1;
      dsr_n_r <= alt_sel[2] ? (pad_i[2] ^ cfg_r[2].invert) : 1'b1;
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign pad_o = pad_o_r;
  assign pad_oe = pad_oe_r;
  assign gpio_in = gpio_in_r;
  assign serial2_receive_data = rxd_r;
  assign serial2_data_set_ready_n = dsr_n_r;

endmodule

// file: testbench/gpc_pin_config_monitor.sv
// bus and pin checks for the pin configuration block
`timescale 1ns/10ps
module gpc_pin_config_monitor (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [gpc_pkg::WB_DW-1:0] wb_dat_o,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pad_oe,
  input wire logic serial2_receive_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_take: assert property (p_take) else $error("no ack");
  property p_pulse; wb_ack_o |=> !wb_ack_o [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_cause: assert property (p_cause) else $error("stray ack");
  property p_idle; !wb_cyc_i |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("idle ack");
  property p_rsv; wb_ack_o && !wb_we_i |-> wb_dat_o[31:4] == 28'h0 ||
    wb_dat_o[31:4] == 28'h8; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_hold; wb_ack_o |=> $stable(wb_dat_o); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_boot; $fell(srst) |-> pad_oe == 4'h0; endproperty
  a_boot: assert property (p_boot) else $error("pin driven");
  property p_rx; $fell(srst) |-> serial2_receive_data; endproperty
  a_rx: assert property (p_rx) else $error("rx low");
endmodule
bind gpc_pin_config gpc_pin_config_monitor mon_u (.core_clk, .srst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_dat_o, .pad_oe,
  .serial2_receive_data);

// file: testbench/gpc_pads_model.sv
// board side of the four pins
`timescale 1ns/10ps
module gpc_pads_model (
  input wire logic [3:0] pad_o,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] ext_drv,
  output logic [3:0] pad_i
);
  // a released pin shows the board level, never the last driven one
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_drv);
endmodule

// file: testbench/gpc_pin_config_tb.sv
// self-checking bench for the pin configuration block
`timescale 1ns/10ps
module gpc_pin_config_tb;
  logic core_clk = 0, srst = 1, main_por = 0, pci_reset = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [9:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'h1, pad_o, pad_oe, pad_i, gpio_in;
  logic [3:0] gpio_out = 4'h8, ext_drv = 4'h0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic serial2_transmit_data = 1, serial2_request_to_send_n = 0;
  logic serial2_receive_data, serial2_data_set_ready_n;
  int n_errors = 0, total_checks = 0;
  gpc_pads_model pads_u (.*);
  gpc_pin_config dut_u (.*);
  initial forever #20 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [9:0] a, input logic [7:0] d, input w);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge core_clk);
    n_errors++;
    results;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 0;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      bus(10'h104 + 10'(4 * i), 0, 0);
      chk(q, 32'(i != 1 && i != 4));
    end
    bus(10'h108, 8'hFF, 1);
    bus(10'h108, 0, 0);
    chk(q, 32'h8F);
    bus(10'h104, 8'h03, 1);
    chk(gpio_in[0], 1);
    bus(10'h104, 8'h04, 1);
    chk(serial2_receive_data, 0);
    for (int k = 1; k < 3; k++) begin
      bus(10'h108, 8'h04, 1);
      chk({pad_oe[1], pad_o[1]}, 3);
      {pci_reset, main_por} <= 2'(k);
      @(posedge core_clk);
      {pci_reset, main_por} <= 0;
      bus(10'h108, 0, 0);
      chk(q, 0);
    end
    bus(10'h104, 0, 0);
    chk(q, 4);
    bus(10'h10C, 8'h04, 1);
    chk(serial2_data_set_ready_n, 0);
    bus(10'h110, 8'h80, 1);
    chk(pad_oe[3], 0);
    bus(10'h110, 8'h04, 1);
    chk({pad_oe[3], pad_o[3]}, 2);
    results;
  end
endmodule
